// ---- hw/fcrc_pkg.sv ----
// package: register map, field positions, commands and states for the flash rewrite controller
package fcrc_pkg;
   // register byte offsets
   localparam logic [7:0] MODE0_OFF = 8'h00;
   localparam logic [7:0] MODE1_OFF = 8'h04;
   localparam logic [7:0] MODE3_OFF = 8'h08;
   localparam logic [7:0] CMD_OFF = 8'h0C;
   localparam logic [7:0] ADDR_OFF = 8'h10;
   localparam logic [7:0] STAT_OFF = 8'h14;
   localparam logic [7:0] CFG_OFF = 8'h18;
   // flash_mode_reg0 fields
   localparam int REWR_EN_BIT = 1;
   localparam int LOCK_DIS_BIT = 2;
   localparam int FRES_SEL_BIT = 3;
   // config fields
   localparam int WDT_SRC_BIT = 0;
   // status fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ABORT_BIT = 1;
   localparam int ST_REFUSE_BIT = 2;
   localparam int ST_LOCKED_BIT = 3;
   localparam int ST_ADDRMATCH_BIT = 4;
   localparam int ST_RDARR_BIT = 5;
   // reset values
   localparam logic [7:0] MODE0_RST = 8'h01;
   localparam logic [7:0] MODE1_RST = 8'h00;
   localparam logic [7:0] MODE3_RST = 8'h00;
   // command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_PROGRAM = 8'h41;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
   // operation timing in cycles
   localparam int PROG_CYCLES = 64;
   localparam int ERASE_CYCLES = 256;
   localparam int NUM_BLOCKS = 8;
   typedef enum logic [1:0] {fcrc_idle, fcrc_prog, fcrc_erase, fcrc_lockp} fcrc_state_type;
endpackage

// ---- hw/fcrc_set_guard.sv ----
// two-write set guard: a bit is set only by 0 then 1 written back to back
`timescale 1ns/1ps
module fcrc_set_guard
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // write events
   input wire logic wr_mode0,
   input wire logic other_wr,
   input wire logic wr_val,
   input wire logic nmi_high,
   input wire logic force_clr,
   // result
   output logic set_bit_r
);
   logic armed_r;

   // arm on a 0 write with nmi_high, set on the next write if it is a 1 and nmi_high is still high
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         armed_r <= 1'b0;
         set_bit_r <= 1'b0;
      end
      else if (force_clr)
      begin
         armed_r <= 1'b0;
         set_bit_r <= 1'b0;
      end
      else if (wr_mode0)
      begin
         armed_r <= !wr_val && nmi_high;
         if (!wr_val)
            set_bit_r <= 1'b0;
         else if (armed_r && nmi_high)
            set_bit_r <= 1'b1;
      end
      else if (other_wr)
         armed_r <= 1'b0;
   end
endmodule

// ---- hw/fcrc_top.sv ----
// flash rewrite controller: apb registers, command sequencer, forced abort
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module fcrc_top
#(
   parameter int ADDR_W = 16,
   parameter int BLK_SHIFT = 12
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // high-priority interrupt requests
   input wire logic nmi_req,
   input wire logic nmi_pin_high,
   input wire logic wdt_req,
   input wire logic vmon_req,
   input wire logic osc_stop_req,
   input wire logic addr_match_req,
   // flash array
   output logic flash_busy,
   output logic flash_we,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [7:0] flash_data,
   output logic flash_erase
);
   import fcrc_pkg::*;

   logic [7:0] mode0_r, mode1_r, mode3_r;
   logic [ADDR_W-1:0] addr_r;
   logic [7:0] data_r;
   logic [7:0] cfg_r;
   logic lock_r [NUM_BLOCKS];
   logic abort_r, refuse_r, addrmatch_r, read_array_r;
   logic [8:0] cnt_r;
   fcrc_state_type state_r;
   logic rewr_en, lock_dis, fres_mode;
   logic access, wr, wr_mode0, force_init, op_busy;
   logic wdt_hit, hp_req;
   logic [31:0] rd_nxt;
   logic [2:0] blk;

   assign access = psel && penable;
   assign wr = access && pwrite;
   assign wr_mode0 = wr && paddr == MODE0_OFF && pstrb[0];
   assign op_busy = state_r != fcrc_idle;
   assign fres_mode = mode0_r[FRES_SEL_BIT];
   assign blk = addr_r[BLK_SHIFT +: 3];

   // high-priority requests in rewrite mode, except address match and the watchdog when fres_mode is set without WDT_SRC_BIT, force abort and init
   assign wdt_hit = wdt_req && (!fres_mode || cfg_r[WDT_SRC_BIT]);
   assign hp_req = nmi_req || vmon_req || osc_stop_req || wdt_hit;
   assign force_init = rewr_en && hp_req;

   // guarded set of rewrite enable and lock disable
   fcrc_set_guard u_rewr
   (
      .clk(clk),
      .resetn(resetn),
      .wr_mode0(wr_mode0),
      .other_wr(wr && !wr_mode0),
      .wr_val(pwdata[REWR_EN_BIT]),
      .nmi_high(nmi_pin_high),
      .force_clr(force_init),
      .set_bit_r(rewr_en)
   );

   fcrc_set_guard u_lockdis
   (
      .clk(clk),
      .resetn(resetn),
      .wr_mode0(wr_mode0 && rewr_en),
      .other_wr(wr && !wr_mode0),
      .wr_val(pwdata[LOCK_DIS_BIT]),
      .nmi_high(nmi_pin_high),
      .force_clr(force_init || !rewr_en),
      .set_bit_r(lock_dis)
   );

   // plain bits of the mode registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mode0_r <= MODE0_RST;
         mode1_r <= MODE1_RST;
         mode3_r <= MODE3_RST;
         cfg_r <= 8'h00;
      end
      else if (force_init)
      begin
         mode0_r <= MODE0_RST;
         mode1_r <= MODE1_RST;
         mode3_r <= MODE3_RST;
      end
      else if (wr)
      begin
         if (wr_mode0 && !rewr_en)
            mode0_r[FRES_SEL_BIT] <= pwdata[FRES_SEL_BIT];
         if (paddr == MODE1_OFF && pstrb[0])
            mode1_r <= pwdata[7:0];
         if (paddr == MODE3_OFF && pstrb[0])
            mode3_r <= pwdata[7:0];
         if (paddr == CFG_OFF && pstrb[0])
            cfg_r <= pwdata[7:0];
      end
   end

   // command register write: address then command with data
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         addr_r <= '0;
      else if (wr && paddr == ADDR_OFF && !op_busy)
         addr_r <= pwdata[ADDR_W-1:0];
   end

   // sequencer
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= fcrc_idle;
         cnt_r <= 9'h000;
         data_r <= 8'h00;
         refuse_r <= 1'b0;
         read_array_r <= 1'b1;
      end
      else if (force_init)
      begin
         state_r <= fcrc_idle;
         cnt_r <= 9'h000;
         read_array_r <= 1'b1;
      end
      else if (op_busy)
      begin
         if (cnt_r == 9'h000)
            state_r <= fcrc_idle;
         else
            cnt_r <= cnt_r - 9'h001;
      end
      else if (wr && paddr == CMD_OFF && pstrb[0])
      begin
         data_r <= pwdata[15:8];
         refuse_r <= 1'b0;
         if (pwdata[7:0] == CMD_READ_ARRAY)
            read_array_r <= 1'b1;
         else if (addr_r[0] || !rewr_en)
            refuse_r <= 1'b1;
         else if (pwdata[7:0] == CMD_PROGRAM)
         begin
            state_r <= fcrc_prog;
            cnt_r <= 9'(PROG_CYCLES - 1);
            read_array_r <= 1'b0;
         end
         else if (pwdata[7:0] == CMD_ERASE)
         begin
            if (lock_r[blk] && !lock_dis)
               refuse_r <= 1'b1;
            else
            begin
               state_r <= fcrc_erase;
               cnt_r <= 9'(ERASE_CYCLES - 1);
               read_array_r <= 1'b0;
            end
         end
         else if (pwdata[7:0] == CMD_LOCK_PROG)
         begin
            state_r <= fcrc_lockp;
            cnt_r <= 9'(PROG_CYCLES - 1);
            read_array_r <= 1'b0;
         end
         else
            refuse_r <= 1'b1;
      end
   end

   // lock bits: 1 locked; an aborted erase leaves its block locked
   generate
      for (genvar gi = 0; gi < NUM_BLOCKS; gi++)
      begin : g_lock
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               lock_r[gi] <= 1'b0;
            else if (force_init && state_r == fcrc_erase && blk == 3'(gi))
               lock_r[gi] <= 1'b1;
            else if (op_busy && cnt_r == 9'h000 && blk == 3'(gi))
            begin
               if (state_r == fcrc_erase)
                  lock_r[gi] <= 1'b0;
               else if (state_r == fcrc_lockp)
                  lock_r[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   // sticky abort and address-match-ignored flags, set wins
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         abort_r <= 1'b0;
         addrmatch_r <= 1'b0;
      end
      else
      begin
         if (force_init && op_busy)
            abort_r <= 1'b1;
         else if (wr && paddr == STAT_OFF && pwdata[ST_ABORT_BIT])
            abort_r <= 1'b0;
         if (addr_match_req && rewr_en && !fres_mode)
            addrmatch_r <= 1'b1;
         else if (wr && paddr == STAT_OFF && pwdata[ST_ADDRMATCH_BIT])
            addrmatch_r <= 1'b0;
      end
   end

   // flash array strobes
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flash_busy <= 1'b0;
         flash_we <= 1'b0;
         flash_erase <= 1'b0;
         flash_addr <= '0;
         flash_data <= 8'h00;
      end
      else
      begin
         flash_busy <= op_busy && !force_init;
         flash_we <= op_busy && !force_init && cnt_r == 9'h000 && state_r == fcrc_prog;
         flash_erase <= op_busy && !force_init && cnt_r == 9'h000 && state_r == fcrc_erase;
         flash_addr <= addr_r;
         flash_data <= data_r;
      end
   end

   // register read mux
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         MODE0_OFF: rd_nxt = {24'h000000, mode0_r[7:3], lock_dis, rewr_en, !op_busy};
         MODE1_OFF: rd_nxt = {24'h000000, mode1_r};
         MODE3_OFF: rd_nxt = {24'h000000, mode3_r};
         ADDR_OFF: rd_nxt = 32'(addr_r);
         STAT_OFF: rd_nxt = {26'h0, read_array_r, addrmatch_r, lock_r[blk], refuse_r, abort_r, op_busy};
         CFG_OFF: rd_nxt = {24'h000000, cfg_r};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // apb slave: no wait state, error on any address above CFG_OFF
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && paddr > CFG_OFF;
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
            prdata <= rd_nxt;
      end
   end
endmodule

// ---- testbench/fcrc_top_bench.sv ----
// testbench: registers, commands, aborts and lock handling
`timescale 1ns/1ps
module fcrc_top_bench;
   import fcrc_pkg::*;
   logic clk, resetn, psel, penable, pwrite, pin_hi, pready, pslverr, busy, we, er, got, err;
   logic [7:0] paddr, fdata, seen;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [4:0] req;
   logic [15:0] faddr, seen_a;
   int bad_count = 0;
   int num_checks = 0;
   fcrc_top fcrc_top_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nmi_req(req[0]), .nmi_pin_high(pin_hi), .wdt_req(req[1]), .vmon_req(req[2]), .osc_stop_req(req[3]),
      .addr_match_req(req[4]), .flash_busy(busy), .flash_we(we), .flash_addr(faddr), .flash_data(fdata),
      .flash_erase(er));
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] seen_v);
      num_checks++;
      if (seen_v !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen_v);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= (a == MODE0_OFF) ? 4'h1 : 4'hF;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run_op(logic [7:0] m, logic lk, logic [7:0] cmd, logic [15:0] a, logic [4:0] r, logic exp);
      xfer(1, MODE0_OFF, {24'h0, m});
      xfer(1, MODE0_OFF, {24'h0, m | 8'h02});
      if (lk)
      begin
         xfer(1, MODE0_OFF, 32'h02);
         xfer(1, MODE0_OFF, 32'h06);
      end
      xfer(1, ADDR_OFF, {16'h0, a});
      xfer(1, CMD_OFF, {16'h0, 8'h5A, cmd});
      got = 0;
      for (int n = 0; n < 400; n++)
      begin
         @(posedge clk);
         if (n == 10)
            req <= r;
         if (we === 1'b1)
         begin
            seen = fdata;
            seen_a = faddr;
         end
         if (we === 1'b1 || er === 1'b1)
            got = 1;
      end
      req <= 5'h00;
      chk("commit", exp, got);
      xfer(0, MODE0_OFF, 0);
      if (r[3:0] != 0 && !exp)
         chk("mode0 forced init", MODE0_RST, rd[7:0]);
      xfer(1, CMD_OFF, {24'h0, CMD_READ_ARRAY});
      xfer(1, MODE0_OFF, {24'h0, m});
   endtask
   task t_reset;
      xfer(0, MODE0_OFF, 0);
      chk("mode0 reset", MODE0_RST, rd[7:0]);
      xfer(0, MODE1_OFF, 0);
      chk("mode1 reset", MODE1_RST, rd[7:0]);
      xfer(0, MODE3_OFF, 0);
      chk("mode3 reset", MODE3_RST, rd[7:0]);
      xfer(0, 8'h1C, 0);
      chk("unmapped err", 1, err);
      $display("reset test done");
   endtask
   task t_guard;
      xfer(1, MODE0_OFF, 32'h00);
      xfer(1, CFG_OFF, 32'h00);
      xfer(1, MODE0_OFF, 32'h02);
      xfer(0, MODE0_OFF, 0);
      chk("enable after gap", 0, rd[REWR_EN_BIT]);
      pin_hi <= 1'b0;
      xfer(1, MODE0_OFF, 32'h00);
      xfer(1, MODE0_OFF, 32'h02);
      pin_hi <= 1'b1;
      xfer(0, MODE0_OFF, 0);
      chk("enable nmi low", 0, rd[REWR_EN_BIT]);
      xfer(1, CMD_OFF, {16'h0, 8'h5A, CMD_PROGRAM});
      xfer(0, STAT_OFF, 0);
      chk("refuse disabled", 1, rd[ST_REFUSE_BIT]);
      chk("busy disabled", 0, busy);
      xfer(1, MODE0_OFF, 32'h00);
      xfer(1, MODE0_OFF, 32'h02);
      xfer(0, MODE0_OFF, 0);
      chk("enable set", 1, rd[REWR_EN_BIT]);
      xfer(1, MODE0_OFF, 32'h00);
      $display("guard test done");
   endtask
   task t_ops;
      run_op(8'h00, 0, CMD_PROGRAM, 16'h0100, 5'h00, 1);
      chk("program data", 8'h5A, seen);
      chk("program addr", 16'h0100, seen_a);
      run_op(8'h00, 0, CMD_PROGRAM, 16'h0101, 5'h00, 0);
      run_op(8'h00, 0, CMD_PROGRAM, 16'h0102, 5'h10, 1);
      xfer(0, STAT_OFF, 0);
      chk("addr match flag", 1, rd[ST_ADDRMATCH_BIT]);
      chk("read array flag", 1, rd[ST_RDARR_BIT]);
      for (int k = 0; k < 8; k++)
         run_op(k[2] ? 8'h08 : 8'h00, 0, CMD_PROGRAM, 16'h0108, 5'(1 << k[1:0]), k == 5);
      xfer(0, STAT_OFF, 0);
      chk("abort flag", 1, rd[ST_ABORT_BIT]);
      xfer(1, STAT_OFF, 32'h12);
      xfer(0, STAT_OFF, 0);
      chk("abort cleared", 0, rd[ST_ABORT_BIT]);
      xfer(1, CFG_OFF, 32'h01);
      run_op(8'h08, 0, CMD_PROGRAM, 16'h0106, 5'h02, 0);
      $display("operation test done");
   endtask
   task t_lock;
      run_op(8'h00, 0, CMD_ERASE, 16'h1000, 5'h01, 0);
      run_op(8'h00, 0, CMD_ERASE, 16'h1000, 5'h00, 0);
      run_op(8'h00, 1, CMD_ERASE, 16'h1000, 5'h00, 1);
      $display("lock test done");
   endtask
   initial
   begin
      resetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      pstrb = 0;
      req = 0;
      pin_hi = 1;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_guard();
      t_ops();
      t_lock();
      end_sim();
   end
   initial
   begin
      #500000;
      bad_count++;
      end_sim();
   end
endmodule
bind fcrc_top fcrc_top_sva fcrc_top_sva_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .nmi_req(nmi_req), .vmon_req(vmon_req),
   .osc_stop_req(osc_stop_req), .flash_busy(flash_busy), .flash_we(flash_we), .flash_erase(flash_erase));

// ---- testbench/fcrc_top_sva.sv ----
// checker: apb answer and forced abort properties
`timescale 1ns/1ps
module fcrc_top_sva
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // requests and flash
   input wire logic nmi_req,
   input wire logic vmon_req,
   input wire logic osc_stop_req,
   input wire logic flash_busy,
   input wire logic flash_we,
   input wire logic flash_erase
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_setup_answer: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_answer_access: assert property (pready |-> psel && penable)
      else $error("answer outside access");
   a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
      else $error("no error on unmapped");
   a_err_mapped: assert property (pready && paddr <= 8'h18 |-> !pslverr)
      else $error("error on mapped");
   a_nmi_abort: assert property (flash_busy && nmi_req |-> ##[1:3] !flash_busy)
      else $error("nmi did not abort");
   a_src_abort: assert property (flash_busy && (vmon_req || osc_stop_req) |-> ##[1:3] !flash_busy)
      else $error("monitor did not abort");
   a_prog_pulse: assert property (flash_we |=> !flash_we)
      else $error("program strobe held");
   a_erase_pulse: assert property (flash_erase |=> !flash_erase)
      else $error("erase strobe held");
endmodule
